// ---- logic/pcc_pkg.sv ----
// Purpose: Shared constants and types of the port remap and config block
// Assumes: Register addresses are eight bits, data is one byte
// Notes: Protected ranges are shared by the write gate and its checks

package pcc_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] PCC_ADDR_PORT3_MAP = 8'hFC;
  localparam logic [7:0] PCC_ADDR_STATUS = 8'hFF;
  localparam logic [7:0] PCC_PORT3_MAP_RST = 8'h03;
  localparam logic [7:0] PCC_STATUS_RST = 8'h00;
  localparam logic [7:0] PCC_UNMAPPED_RD = 8'h00;
  localparam logic [7:0] PCC_PTR_RST = 8'h00;
  localparam logic [7:0] PCC_PTR_STEP = 8'h01;

  // ********************************************************************
  // Field layout
  // ********************************************************************
  localparam int PCC_SRST_BIT = 1;
  localparam int PCC_PROT_BIT = 0;
  localparam int PCC_CODE_MSB = 3;
  localparam logic [3:0] PCC_CODE_DIS = 4'h0;
  localparam logic [3:0] PCC_CODE_LAST = 4'h3;
  localparam logic [1:0] PCC_NATURAL_PORT = 2'h3;
  localparam logic [1:0] PCC_NO_PORT = 2'h0;

  // ********************************************************************
  // Protected configuration ranges and serial constants
  // ********************************************************************
  localparam logic [7:0] PCC_PROT_LO_END = 8'hE1;
  localparam logic [7:0] PCC_PROT_HI_BEG = 8'hEF;
  localparam logic [2:0] PCC_BIT_LAST = 3'h7;
  localparam logic [2:0] PCC_BIT_STEP = 3'h1;
  localparam logic [6:0] PCC_SLAVE_ADDR_DEF = 7'h08;

  typedef enum logic [2:0] {
    PCC_ST_IDLE, PCC_ST_RX, PCC_ST_ACK, PCC_ST_TX, PCC_ST_TXACK,
    PCC_ST_WAIT
  } pcc_state_t;

  typedef enum logic [1:0] {
    PCC_ROLE_ADDR, PCC_ROLE_REG, PCC_ROLE_DATA
  } pcc_role_t;

  // True for addresses that the protect bit locks
  function automatic logic pcc_is_protected(input logic [7:0] a);
    pcc_is_protected = (a <= PCC_PROT_LO_END) || (a >= PCC_PROT_HI_BEG);
  endfunction

endpackage

// ---- logic/pcc_line_if.sv ----
// Purpose: Carries synchronised serial line events to the engine
// Assumes: All signals are in the clk domain
// Notes: Event signals are one-cycle pulses

`timescale 1ns/100ps

interface pcc_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda_lvl;

  modport det (output scl_rise, scl_fall, start, stop, sda_lvl);
  modport eng (input scl_rise, scl_fall, start, stop, sda_lvl);
endinterface

// ---- logic/pcc_line_detect.sv ----
// Purpose: Synchronise the serial pins and detect edges, start and stop
// Assumes: Pins are asynchronous to clk
// Notes: Events are judged from second and third stages only

`timescale 1ns/100ps

module pcc_line_detect
  import pcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw pin levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Line events
  pcc_line_if.det lp
);

  logic [2:0] scl_q;
  logic [2:0] scl_d;
  logic [2:0] sda_q;
  logic [2:0] sda_d;

  // Shift chain: stage 0 feeds only stage 1
  always_comb begin
    scl_d = {scl_q[1:0], scl_in};
    sda_d = {sda_q[1:0], sda_in};
  end

  // Idle bus is high, so reset to high to avoid a false start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  // Events from stage 1 (current) against stage 2 (previous)
  assign lp.scl_rise = scl_q[1] & ~scl_q[2];
  assign lp.scl_fall = ~scl_q[1] & scl_q[2];
  assign lp.start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign lp.stop = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  assign lp.sda_lvl = sda_q[1];

endmodule

// ---- logic/pcc_port_remap_cfg.sv ----
// Purpose: Serial slave with port 3 remap and status/command registers
// Assumes: scl and sda are open-drain, sampled at 250 MHz
// Notes: Port mapping outputs are registered from the map register

`timescale 1ns/100ps

module pcc_port_remap_cfg
  import pcc_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = PCC_SLAVE_ADDR_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Hub datapath
  input wire logic remap_mode_enable,
  output logic port3_enable,
  output logic [1:0] port3_logical,
  output logic config_protected
);

  // ********************************************************************
  // Line events
  // ********************************************************************
  pcc_line_if ln ();

  pcc_line_detect u_detect (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .lp(ln)
  );

  // ********************************************************************
  // Serial engine
  // ********************************************************************
  pcc_state_t st_q;
  pcc_state_t st_d;
  pcc_role_t role_q;
  pcc_role_t role_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic full_q;
  logic full_d;
  logic rw_q;
  logic rw_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic pend_q;
  logic pend_d;
  logic drive_q;
  logic drive_d;
  logic wr_en;
  logic wr_ok;
  logic [7:0] map_q;
  logic [7:0] map_d;
  logic prot_q;
  logic prot_d;
  logic [7:0] rd_val;

  // Writes land only when unlocked or outside the locked ranges
  assign wr_ok = !prot_q || !pcc_is_protected(ptr_q);

  // Read mux; soft reset bit is never stored, so it reads zero
  always_comb begin
    rd_val = PCC_UNMAPPED_RD;
    if (ptr_q == PCC_ADDR_PORT3_MAP) begin
      rd_val = map_q;
    end else if (ptr_q == PCC_ADDR_STATUS) begin
      rd_val = PCC_STATUS_RST;
      rd_val[PCC_PROT_BIT] = prot_q;
    end
  end

  // Next state of the byte engine
  always_comb begin
    st_d = st_q;
    role_d = role_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    full_d = full_q;
    rw_d = rw_q;
    ptr_d = ptr_q;
    tx_d = tx_q;
    pend_d = pend_q;
    wr_en = 1'b0;
    if (ln.stop) begin
      st_d = PCC_ST_IDLE;
    end else if (ln.start) begin
      st_d = PCC_ST_RX;
      role_d = PCC_ROLE_ADDR;
      cnt_d = '0;
      full_d = 1'b0;
    end else begin
      case (st_q)
        PCC_ST_RX: begin
          if (ln.scl_rise) begin
            sh_d = {sh_q[6:0], ln.sda_lvl};
            cnt_d = cnt_q + PCC_BIT_STEP;
            full_d = (cnt_q == PCC_BIT_LAST);
          end else if (ln.scl_fall && full_q) begin
            full_d = 1'b0;
            cnt_d = '0;
            st_d = PCC_ST_ACK;
            case (role_q)
              PCC_ROLE_ADDR: begin
                if (sh_q[7:1] == SLAVE_ADDR) begin
                  rw_d = sh_q[0];
                end else begin
                  st_d = PCC_ST_WAIT;
                end
              end
              PCC_ROLE_REG: begin
                ptr_d = sh_q;
              end
              default: begin
                // Locked writes are still acknowledged
                wr_en = 1'b1;
                ptr_d = ptr_q + PCC_PTR_STEP;
                if (ptr_q == PCC_ADDR_STATUS && wr_ok &&
                    sh_q[PCC_SRST_BIT]) begin
                  pend_d = 1'b1;
                end
              end
            endcase
          end
        end
        PCC_ST_ACK: begin
          if (ln.scl_fall) begin
            if (pend_q) begin
              // Serial side restarts after the acknowledge
              st_d = PCC_ST_WAIT;
              ptr_d = PCC_PTR_RST;
              pend_d = 1'b0;
            end else if (role_q == PCC_ROLE_ADDR && rw_q) begin
              st_d = PCC_ST_TX;
              tx_d = rd_val;
              ptr_d = ptr_q + PCC_PTR_STEP;
            end else begin
              st_d = PCC_ST_RX;
              role_d = (role_q == PCC_ROLE_ADDR) ? PCC_ROLE_REG :
                       PCC_ROLE_DATA;
            end
          end
        end
        PCC_ST_TX: begin
          if (ln.scl_fall) begin
            tx_d = {tx_q[6:0], 1'b0};
            cnt_d = cnt_q + PCC_BIT_STEP;
            if (cnt_q == PCC_BIT_LAST) begin
              st_d = PCC_ST_TXACK;
              cnt_d = '0;
            end
          end
        end
        PCC_ST_TXACK: begin
          if (ln.scl_rise && ln.sda_lvl) begin
            st_d = PCC_ST_WAIT; // Master NACK ends the read
          end else if (ln.scl_fall) begin
            st_d = PCC_ST_TX;
            tx_d = rd_val;
            ptr_d = ptr_q + PCC_PTR_STEP;
          end
        end
        default: begin
        end
      endcase
    end
    // Pull sda low for acknowledge and for zero data bits
    drive_d = (st_d == PCC_ST_ACK) || (st_d == PCC_ST_TX && !tx_d[7]);
  end

  // Engine registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= PCC_ST_IDLE;
      role_q <= PCC_ROLE_ADDR;
      cnt_q <= '0;
      sh_q <= '0;
      full_q <= 1'b0;
      rw_q <= 1'b0;
      ptr_q <= PCC_PTR_RST;
      tx_q <= '0;
      pend_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      st_q <= st_d;
      role_q <= role_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      full_q <= full_d;
      rw_q <= rw_d;
      ptr_q <= ptr_d;
      tx_q <= tx_d;
      pend_q <= pend_d;
      drive_q <= drive_d;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_q;

  // ********************************************************************
  // Configuration registers
  // ********************************************************************

  // Map and protect updates; protect is sticky until the pin reset
  always_comb begin
    map_d = map_q;
    prot_d = prot_q;
    if (wr_en && wr_ok) begin
      if (ptr_q == PCC_ADDR_PORT3_MAP) begin
        map_d = sh_q;
      end else if (ptr_q == PCC_ADDR_STATUS) begin
        prot_d = prot_q | sh_q[PCC_PROT_BIT];
        if (sh_q[PCC_SRST_BIT]) begin
          map_d = PCC_PORT3_MAP_RST;
        end
      end
    end
  end

  // Mapping decode; codes above three fall back to disabled
  logic p3_en_d;
  logic [1:0] p3_log_d;
  logic p3_en_q;
  logic [1:0] p3_log_q;
  always_comb begin
    p3_en_d = 1'b1;
    p3_log_d = PCC_NATURAL_PORT;
    if (remap_mode_enable) begin
      if (map_q[PCC_CODE_MSB:0] == PCC_CODE_DIS ||
          map_q[PCC_CODE_MSB:0] > PCC_CODE_LAST) begin
        p3_en_d = 1'b0;
        p3_log_d = PCC_NO_PORT;
      end else begin
        p3_log_d = map_q[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map_q <= PCC_PORT3_MAP_RST;
      prot_q <= 1'b0;
      p3_en_q <= 1'b1;
      p3_log_q <= PCC_NATURAL_PORT;
    end else begin
      map_q <= map_d;
      prot_q <= prot_d;
      p3_en_q <= p3_en_d;
      p3_log_q <= p3_log_d;
    end
  end

  assign port3_enable = p3_en_q;
  assign port3_logical = p3_log_q;
  assign config_protected = prot_q;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_map_write;
    wr_en && wr_ok && ptr_q == PCC_ADDR_PORT3_MAP |=>
      map_q == $past(sh_q);
  endproperty
  a_map_write: assert property (p_map_write)
    else $error("map write not stored");

  property p_disabled;
    remap_mode_enable && (map_q[3:0] == 4'h0 || map_q[3:0] > 4'h3) |=>
      !port3_enable;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("port 3 not disabled");

  property p_mapped;
    remap_mode_enable && map_q[3:0] inside {[4'h1:4'h3]} |=>
      port3_enable && port3_logical == $past(map_q[1:0]);
  endproperty
  a_mapped: assert property (p_mapped)
    else $error("port 3 logical number wrong");

  property p_natural;
    !remap_mode_enable |=> port3_enable && port3_logical == 2'h3;
  endproperty
  a_natural: assert property (p_natural)
    else $error("natural numbering lost");

  property p_srst;
    wr_en && wr_ok && ptr_q == PCC_ADDR_STATUS && sh_q[1] |=>
      map_q == 8'h03 ##1 st_q != PCC_ST_TX;
  endproperty
  a_srst: assert property (p_srst)
    else $error("soft reset did not restore");

  property p_srst_zero;
    st_q == PCC_ST_ACK && ln.scl_fall && rw_q && !pend_q &&
      role_q == PCC_ROLE_ADDR && ptr_q == PCC_ADDR_STATUS |=>
      tx_q[7:1] == 7'h00;
  endproperty
  a_srst_zero: assert property (p_srst_zero)
    else $error("status reads nonzero high bits");

  property p_locked;
    wr_en && prot_q && pcc_is_protected(ptr_q) |=>
      $stable(map_q) && prot_q;
  endproperty
  a_locked: assert property (p_locked)
    else $error("protected write changed a register");

  property p_sticky;
    prot_q |=> prot_q [*2];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("protect bit cleared without reset");

  property p_incr;
    wr_en |=> ptr_q == $past(ptr_q) + 8'h01;
  endproperty
  a_incr: assert property (p_incr)
    else $error("register address did not advance");

  property p_ack_locked;
    wr_en && prot_q |=> st_q == PCC_ST_ACK && !sda_oe_n;
  endproperty
  a_ack_locked: assert property (p_ack_locked)
    else $error("protected write not acknowledged");

  property p_once;
    prot_q && wr_en && ptr_q == PCC_ADDR_STATUS && !sh_q[0] |=>
      prot_q ##1 prot_q;
  endproperty
  a_once: assert property (p_once)
    else $error("protect bit changed after set");

endmodule

// ---- dv/pcc_i2c_master.sv ----
// Purpose: Serial bus master model standing in for the host system-on-chip
// Assumes: Bench calls its tasks; sda is open drain with a pull-up
// Notes: half sets each scl phase in clk cycles, so pace can be slowed

`timescale 1ns/100ps

module pcc_i2c_master (
  // Clock
  input wire logic clk,
  // Bus lines
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  int half = 8;

  // Idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // ******************************************************************
  // Bus phases
  // ******************************************************************
  // Every change lands at a rising clk edge, then holds half cycles
  task automatic hold();
    repeat (half) @(posedge clk);
  endtask

  // Start or repeated start: sda falls while scl is high
  task automatic start();
    @(posedge clk);
    sda_drv <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_drv <= 1'b0;
    hold();
    scl <= 1'b0;
    hold();
  endtask

  // Stop: sda rises while scl is high
  task automatic stop();
    @(posedge clk);
    sda_drv <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda_drv <= 1'b1;
    hold();
  endtask

  // Data set a full phase before scl rises, sampled late in the high
  task automatic bit_io(input logic b, output logic s);
    @(posedge clk);
    sda_drv <= b;
    hold();
    scl <= 1'b1;
    hold();
    s = sda_line;
    scl <= 1'b0;
    hold();
  endtask

  // Byte out MSB first, then a released bit for the slave's answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Byte in MSB first; last byte answered with a release
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, s);
  endtask
endmodule

// ---- dv/pcc_port_remap_cfg_tb_top.sv ----
// Purpose: Self-checking bench of the port remap and config registers
// Assumes: Registers are reached only through the serial master model
// Notes: A non-default slave address exercises the parameter

`timescale 1ns/100ps

module pcc_port_remap_cfg_tb_top;
  import pcc_pkg::*;

  localparam logic [6:0] DEV_ADDR = 7'h2A;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic remap_mode_enable = 1'b0;
  logic scl;
  logic sda_drv;
  logic sda_w;
  logic sda_out;
  logic sda_oe_n;
  logic port3_enable;
  logic config_protected;
  logic [1:0] port3_logical;
  logic ack;
  logic [7:0] rd0;
  logic [7:0] rd1;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  // Wired-and of both drivers; the pull-up wins when nobody pulls low
  assign sda_w = sda_drv & (sda_oe_n ? 1'b1 : sda_out);

  pcc_port_remap_cfg #(.SLAVE_ADDR(DEV_ADDR)) u_dut (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl),
    .sda_in(sda_w),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .remap_mode_enable(remap_mode_enable),
    .port3_enable(port3_enable),
    .port3_logical(port3_logical),
    .config_protected(config_protected)
  );

  pcc_i2c_master u_master (
    .clk(clk),
    .scl(scl),
    .sda_drv(sda_drv),
    .sda_line(sda_w)
  );

  // ******************************************************************
  // Compare and report
  // ******************************************************************
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ******************************************************************
  // Register access
  // ******************************************************************
  // Pointer byte follows the slave address; every byte must be answered
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    u_master.start();
    u_master.send_byte({DEV_ADDR, 1'b0}, ack);
    cmp_bit(ack, 1'b1);
    u_master.send_byte(a, ack);
    cmp_bit(ack, 1'b1);
    u_master.send_byte(d, ack);
    cmp_bit(ack, 1'b1);
    u_master.stop();
  endtask

  // Pointer set by a write, then repeated start and n bytes read back
  task automatic reg_rd(input logic [7:0] a, input int n);
    u_master.start();
    u_master.send_byte({DEV_ADDR, 1'b0}, ack);
    cmp_bit(ack, 1'b1);
    u_master.send_byte(a, ack);
    cmp_bit(ack, 1'b1);
    u_master.start();
    u_master.send_byte({DEV_ADDR, 1'b1}, ack);
    cmp_bit(ack, 1'b1);
    u_master.recv_byte(n == 1, rd0);
    if (n == 2) begin
      u_master.recv_byte(1'b1, rd1);
    end
    u_master.stop();
  endtask

  // Port outputs are registered, so let a few edges pass first
  task automatic chk_port(input logic en, input logic [1:0] lg);
    repeat (4) @(posedge clk);
    cmp_bit(port3_enable, en);
    cmp_byte({6'h00, port3_logical}, {6'h00, lg});
  endtask

  // Hang guard well beyond the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      $display("[FAIL] %0t run did not finish", $time);
      print_verdict();
    end
  end

  // ******************************************************************
  // Test sequence
  // ******************************************************************
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    cmp_bit(config_protected, 1'b0);
    chk_port(1'b1, 2'h3);
    reg_rd(PCC_ADDR_PORT3_MAP, 1);
    cmp_byte(rd0, 8'h03);
    reg_rd(PCC_ADDR_STATUS, 1);
    cmp_byte(rd0, 8'h00);
    // Every low-nibble code; software keeps the upper nibble zero
    remap_mode_enable <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      reg_wr(PCC_ADDR_PORT3_MAP, 8'(c));
      if (c >= 1 && c <= 3) begin
        chk_port(1'b1, 2'(c));
      end else begin
        chk_port(1'b0, 2'h0);
      end
    end
    reg_rd(PCC_ADDR_PORT3_MAP, 1);
    cmp_byte(rd0, 8'h0F);
    // A single enabled port numbered from one
    reg_wr(PCC_ADDR_PORT3_MAP, 8'h01);
    chk_port(1'b1, 2'h1);
    remap_mode_enable <= 1'b0;
    chk_port(1'b1, 2'h3);
    // Auto-increment from an unmapped place into the map register
    reg_rd(8'hFB, 2);
    cmp_byte(rd0, 8'h00);
    cmp_byte(rd1, 8'h01);
    // Foreign slave address is left unanswered
    u_master.start();
    u_master.send_byte({DEV_ADDR ^ 7'h01, 1'b0}, ack);
    cmp_bit(ack, 1'b0);
    u_master.stop();
    // Soft reset; upper status bits stay zero
    reg_wr(PCC_ADDR_STATUS, 8'h02);
    reg_rd(PCC_ADDR_STATUS, 1);
    cmp_byte(rd0, 8'h00);
    reg_rd(PCC_ADDR_PORT3_MAP, 1);
    cmp_byte(rd0, 8'h03);
    // Protect under a slow master
    u_master.half = 20;
    remap_mode_enable <= 1'b1;
    reg_wr(PCC_ADDR_STATUS, 8'h01);
    cmp_bit(config_protected, 1'b1);
    reg_wr(PCC_ADDR_PORT3_MAP, 8'h02);
    reg_rd(PCC_ADDR_PORT3_MAP, 1);
    cmp_byte(rd0, 8'h03);
    reg_wr(PCC_ADDR_STATUS, 8'h00);
    cmp_bit(config_protected, 1'b1);
    reg_wr(PCC_ADDR_STATUS, 8'h02);
    reg_rd(PCC_ADDR_STATUS, 1);
    cmp_byte(rd0, 8'h01);
    chk_port(1'b1, 2'h3);
    u_master.half = 8;
    // Only the external reset lifts the lock
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    cmp_bit(config_protected, 1'b0);
    reg_wr(PCC_ADDR_PORT3_MAP, 8'h02);
    reg_rd(PCC_ADDR_PORT3_MAP, 1);
    cmp_byte(rd0, 8'h02);
    chk_port(1'b1, 2'h2);
    print_verdict();
  end
endmodule
